// [scpw_map.svh]
`ifndef SCPW_MAP_SVH
`define SCPW_MAP_SVH

// Register word offsets on the plain register port
`define SCPW_OFS_MODE 3'h0
`define SCPW_OFS_TCON 3'h1
`define SCPW_OFS_PLIM 3'h2
`define SCPW_OFS_DUTY 3'h3
`define SCPW_OFS_PHASE 3'h4
`define SCPW_OFS_COUNT 3'h5
`define SCPW_OFS_DACT 3'h6
`define SCPW_OFS_PACT 3'h7

// Field positions in the mode control register
`define SCPW_MODE_B1 7
`define SCPW_MODE_B0 6
`define SCPW_MODE_B2 3

// Field positions in the period timer control register
`define SCPW_TCON_ON 2
`define SCPW_TCON_PS_HI 1
`define SCPW_TCON_PS_LO 0

// Reset values
`define SCPW_RST_BYTE 8'h00
`define SCPW_RST_ROLE 3'h0
`define SCPW_RST_PS 2'h0

// Sync role codes, ordered {b2, b1, b0}
`define SCPW_ROLE_CODE_ALONE 3'h0
`define SCPW_ROLE_CODE_MASTER 3'h1
`define SCPW_ROLE_CODE_SLAVE 3'h2

// Prescale select codes and terminal counts (ratio minus one)
`define SCPW_PS_SEL_DIV1 2'h0
`define SCPW_PS_SEL_DIV4 2'h1
`define SCPW_PS_LAST_DIV1 4'h0
`define SCPW_PS_LAST_DIV4 4'h3
`define SCPW_PS_LAST_DIV16 4'hf

`endif

// [scpw_pkg.sv]
package scpw_pkg;

    // Operating role of the sync clock pin
    typedef enum logic [1:0] {
        SCPW_ALONE = 2'h0,
        SCPW_MASTER = 2'h1,
        SCPW_SLAVE = 2'h3
    } scpw_role_t;

    // One register port request
    typedef struct packed {
        logic [2:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } scpw_bus_req_t;

    // Period timer control fields
    typedef struct packed {
        logic on;
        logic [1:0] ps_sel;
    } scpw_tcon_t;

endpackage

// [scpw_sync2.sv]
`timescale 1ns/1ps
module scpw_sync2 import scpw_pkg::*; #(
    parameter int WIDTH = 2
) (
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic [WIDTH-1:0] async_i,
    output logic [WIDTH-1:0] sync_o
);

    logic [WIDTH-1:0] meta;

    // Two flops; only the second one is ever read
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            meta <= '0;
            sync_o <= '0;
        end else begin
            meta <= async_i;
            sync_o <= meta;
        end
    end

endmodule

// [scpw_prescale.sv]
`timescale 1ns/1ps
`include "scpw_map.svh"
module scpw_prescale import scpw_pkg::*; (
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic run_i,
    input wire logic [1:0] sel_i,
    output logic tick_o
);

    logic [3:0] cnt;
    logic [3:0] last;

    // Terminal count from the divide ratio select
    always_comb begin
        if (sel_i == `SCPW_PS_SEL_DIV1) begin
            last = `SCPW_PS_LAST_DIV1;
        end else if (sel_i == `SCPW_PS_SEL_DIV4) begin
            last = `SCPW_PS_LAST_DIV4;
        end else begin
            last = `SCPW_PS_LAST_DIV16;
        end
    end

    // Count held while stopped, so a resume continues mid-ratio
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            cnt <= 4'h0;
        end else if (run_i) begin
            if (cnt >= last) begin
                cnt <= 4'h0;
            end else begin
                cnt <= cnt + 4'h1;
            end
        end
    end

    // One-cycle enable at the end of each prescale group
    assign tick_o = run_i & (cnt >= last);

endmodule

// [scpw_top.sv]
// What this block does
// - Only the PWM function exists; no capture or compare logic.
// - Stand-alone: PWM is the system clock, duty never varied per cycle.
// - Gate drive only while clock low, bounding driver on-time.
// - Master: as stand-alone, plus system clock driven on sync pin.
// - Slave: sync pin clock ORed with own period-timer match.
// - Each ORed sync event loads active duty and active phase.
// - Slave restart delayed by phase buffer times oscillator and prescale.
// - Period is period limit plus one, times oscillator and prescale.
// - Counter at limit: next increment clears it and loads active duty.
// - High time is duty buffer times oscillator period and prescale.
// - Duty buffer writes take effect only after next limit match or, in slave role, next master sync edge.
// - Sleep stops the period timer and freezes the generator state; registers stay writable.
// - Sleep keeps the clock pin at its level when sleep began.
// - Wake resumes from the frozen state with no reinitialisation.
// - Unimplemented control register bits read back as zero.
`timescale 1ns/1ps
`include "scpw_map.svh"
module scpw_top import scpw_pkg::*; (
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire scpw_bus_req_t bus_req_i,
    output logic [7:0] rd_data_o,
    input wire logic sleep_i,
    input wire logic sync_clock_pin_i,
    output logic sync_clock_pin_o,
    output logic sync_clock_pin_oe_o,
    output logic clock_output_pin_o,
    input wire logic drive_request_i,
    output logic primary_gate_drive_o,
    output logic period_match_o
);

    // Software visible registers
    logic [2:0] role_sel;
    scpw_tcon_t tcon;
    logic [7:0] period_limit;
    logic [7:0] duty_buffer;
    logic [7:0] phase_buffer;

    // Live state of the generator
    logic [7:0] period_counter;
    logic [7:0] duty_active;
    logic [7:0] phase_active;
    logic [7:0] phase_left;
    logic phase_pending;
    logic sync_prev;
    logic clk_high;

    // Combinational helpers
    scpw_role_t role;
    logic [1:0] pin_sync;
    logic sync_in;
    logic drive_req;
    logic tick;
    logic at_limit;
    logic limit_event;
    logic master_edge;
    logic or_sync;
    logic restart;
    logic next_clk_high;
    logic [7:0] mode_rd;
    logic [7:0] tcon_rd;

    // Sync pin and drive request come from outside the clock domain
    scpw_sync2 #(
        .WIDTH(2)
    ) u_pin_sync (
        .core_clk_i(core_clk_i),
        .rst_i(rst_i),
        .async_i({sync_clock_pin_i, drive_request_i}),
        .sync_o(pin_sync)
    );

    assign sync_in = pin_sync[1];
    assign drive_req = pin_sync[0];

    // Prescaler stops with the timer-on bit and in sleep
    scpw_prescale u_prescale (
        .core_clk_i(core_clk_i),
        .rst_i(rst_i),
        .run_i(tcon.on & ~sleep_i),
        .sel_i(tcon.ps_sel),
        .tick_o(tick)
    );

    // Role decode; unused codes fall back to stand-alone for safety
    always_comb begin
        unique case (role_sel)
            `SCPW_ROLE_CODE_MASTER: role = SCPW_MASTER;
            `SCPW_ROLE_CODE_SLAVE: role = SCPW_SLAVE;
            default: role = SCPW_ALONE;
        endcase
    end

    // Software register writes; only the buffers, never active copies
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            role_sel <= `SCPW_RST_ROLE;
            tcon.on <= 1'b0;
            tcon.ps_sel <= `SCPW_RST_PS;
            period_limit <= `SCPW_RST_BYTE;
            duty_buffer <= `SCPW_RST_BYTE;
            phase_buffer <= `SCPW_RST_BYTE;
        end else if (bus_req_i.wr) begin
            unique case (bus_req_i.addr)
                `SCPW_OFS_MODE: begin
                    role_sel <= {bus_req_i.wdata[`SCPW_MODE_B2],
                                 bus_req_i.wdata[`SCPW_MODE_B1],
                                 bus_req_i.wdata[`SCPW_MODE_B0]};
                end
                `SCPW_OFS_TCON: begin
                    tcon.on <= bus_req_i.wdata[`SCPW_TCON_ON];
                    tcon.ps_sel <= bus_req_i.wdata[`SCPW_TCON_PS_HI:
                                                   `SCPW_TCON_PS_LO];
                end
                `SCPW_OFS_PLIM: begin
                    period_limit <= bus_req_i.wdata;
                end
                `SCPW_OFS_DUTY: begin
                    duty_buffer <= bus_req_i.wdata;
                end
                `SCPW_OFS_PHASE: begin
                    phase_buffer <= bus_req_i.wdata;
                end
                default: begin
                end
            endcase
        end
    end

    // Read images with unimplemented bits forced low
    always_comb begin
        mode_rd = 8'h00;
        mode_rd[`SCPW_MODE_B1] = role_sel[1];
        mode_rd[`SCPW_MODE_B0] = role_sel[0];
        mode_rd[`SCPW_MODE_B2] = role_sel[2];
        tcon_rd = 8'h00;
        tcon_rd[`SCPW_TCON_ON] = tcon.on;
        tcon_rd[`SCPW_TCON_PS_HI:`SCPW_TCON_PS_LO] = tcon.ps_sel;
    end

    // Read data stands one cycle after the strobe, zero otherwise
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            rd_data_o <= 8'h00;
        end else if (bus_req_i.rd) begin
            unique case (bus_req_i.addr)
                `SCPW_OFS_MODE: rd_data_o <= mode_rd;
                `SCPW_OFS_TCON: rd_data_o <= tcon_rd;
                `SCPW_OFS_PLIM: rd_data_o <= period_limit;
                `SCPW_OFS_DUTY: rd_data_o <= duty_buffer;
                `SCPW_OFS_PHASE: rd_data_o <= phase_buffer;
                `SCPW_OFS_COUNT: rd_data_o <= period_counter;
                `SCPW_OFS_DACT: rd_data_o <= duty_active;
                `SCPW_OFS_PACT: rd_data_o <= phase_active;
            endcase
        end else begin
            rd_data_o <= 8'h00;
        end
    end

    // Period match and slave sync events
    assign at_limit = (period_counter == period_limit);
    assign limit_event = tick & at_limit;
    assign master_edge = (role == SCPW_SLAVE) & ~sleep_i
                         & sync_in & ~sync_prev;
    // Master clock ORed with own timer match, slave only
    assign or_sync = master_edge | limit_event;

    // Slave restarts its period once the phase delay has run out
    assign restart = (master_edge && phase_buffer == 8'h00)
                     || (phase_pending && tick
                         && phase_left == 8'h01);

    // Edge history of the synced pin, frozen in sleep
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            sync_prev <= 1'b0;
        end else if (!sleep_i) begin
            sync_prev <= sync_in;
        end
    end

    // Period counter: wraps one increment after matching the limit
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            period_counter <= 8'h00;
        end else if (sleep_i) begin
            period_counter <= period_counter;
        end else if (restart) begin
            period_counter <= 8'h00;
        end else if (tick) begin
            if (at_limit) begin
                period_counter <= 8'h00;
            end else begin
                period_counter <= period_counter + 8'h01;
            end
        end
    end

    // Active duty changes only at a period boundary or sync event
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            duty_active <= `SCPW_RST_BYTE;
        end else if (!sleep_i && or_sync) begin
            duty_active <= duty_buffer;
        end
    end

    // Active phase copied on every ORed sync event in slave role
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            phase_active <= `SCPW_RST_BYTE;
        end else if (!sleep_i && role == SCPW_SLAVE && or_sync) begin
            phase_active <= phase_buffer;
        end
    end

    // Phase delay counter in prescaled ticks after a master edge
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            phase_pending <= 1'b0;
            phase_left <= 8'h00;
        end else if (sleep_i) begin
            phase_pending <= phase_pending;
        end else if (master_edge) begin
            phase_pending <= (phase_buffer != 8'h00);
            phase_left <= phase_buffer;
        end else if (role != SCPW_SLAVE) begin
            phase_pending <= 1'b0;
        end else if (phase_pending && tick) begin
            phase_left <= phase_left - 8'h01;
            if (phase_left == 8'h01) begin
                phase_pending <= 1'b0;
            end
        end
    end

    // Clock is high while the count is below the active duty
    assign next_clk_high = (period_counter < duty_active);

    // Clock pin and gate drive hold their level through sleep
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            clk_high <= 1'b0;
            primary_gate_drive_o <= 1'b0;
        end else if (!sleep_i) begin
            clk_high <= next_clk_high;
            // Driver may only turn on in the low part of the clock
            primary_gate_drive_o <= drive_req & ~next_clk_high;
        end else begin
            clk_high <= clk_high;
            primary_gate_drive_o <= primary_gate_drive_o;
        end
    end

    // Period match flag for other logic, one cycle per wrap
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            period_match_o <= 1'b0;
        end else begin
            period_match_o <= limit_event & ~sleep_i;
        end
    end

    // Only the master drives the shared sync pin
    assign clock_output_pin_o = clk_high;
    assign sync_clock_pin_o = clk_high;
    assign sync_clock_pin_oe_o = (role == SCPW_MASTER);

endmodule

// [scpw_top_props.sv]
`timescale 1ns/1ps
`include "scpw_map.svh"
module scpw_top_props import scpw_pkg::*; (
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire scpw_bus_req_t bus_req_i,
    input wire logic [7:0] rd_data_o,
    input wire logic sleep_i,
    input wire logic sync_clock_pin_i,
    input wire logic sync_clock_pin_o,
    input wire logic sync_clock_pin_oe_o,
    input wire logic clock_output_pin_o,
    input wire logic drive_request_i,
    input wire logic primary_gate_drive_o,
    input wire logic period_match_o
);
    logic [2:0] role;
    logic [2:0] tcon;
    logic [7:0] plim;
    logic [7:0] duty;
    logic [7:0] dprev;
    logic [7:0] drun;
    logic [15:0] hi;
    logic [15:0] gap;
    logic [15:0] ratio;
    logic [1:0] ok;
    logic dirty;
    // Anything that spoils a clean period measurement
    assign ratio = (tcon[1:0] == 2'h0) ? 16'h1 :
        (tcon[1:0] == 2'h1) ? 16'h4 : 16'h10;
    assign dirty = sleep_i || role != `SCPW_ROLE_CODE_ALONE ||
        (bus_req_i.wr && bus_req_i.addr <= `SCPW_OFS_PLIM);
    // Shadow of the writable registers other than the phase buffer
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            role <= 3'h0;
            tcon <= 3'h0;
            plim <= 8'h00;
            duty <= 8'h00;
        end else if (bus_req_i.wr) begin
            case (bus_req_i.addr)
                `SCPW_OFS_MODE: role <= {bus_req_i.wdata[3],
                    bus_req_i.wdata[7:6]};
                `SCPW_OFS_TCON: tcon <= bus_req_i.wdata[2:0];
                `SCPW_OFS_PLIM: plim <= bus_req_i.wdata;
                `SCPW_OFS_DUTY: duty <= bus_req_i.wdata;
                default: ;
            endcase
        end
    end
    // Two clean matches needed, the first may follow a prescale change
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            dprev <= 8'h00;
            drun <= 8'h00;
            hi <= 16'h0;
            gap <= 16'h0;
            ok <= 2'h0;
        end else begin
            dprev <= duty;
            hi <= clock_output_pin_o ? hi + 16'h1 : 16'h0;
            gap <= period_match_o ? 16'h1 : gap + 16'h1;
            if (period_match_o)
                drun <= dprev;
            if (dirty)
                ok <= 2'h0;
            else if (period_match_o && ok != 2'h2)
                ok <= ok + 2'h1;
        end
    end
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (rst_i);
    property p_idle;
        !$past(bus_req_i.rd) |-> rd_data_o == 8'h00;
    endproperty
    a_idle: assert property (p_idle) else $error("read data not idle");
    property p_plim_rd;
        $past(bus_req_i.rd) && $past(bus_req_i.addr) == `SCPW_OFS_PLIM
            |-> rd_data_o == plim;
    endproperty
    a_plim_rd: assert property (p_plim_rd) else $error("limit read bad");
    property p_mode_rd;
        $past(bus_req_i.rd) && $past(bus_req_i.addr) == `SCPW_OFS_MODE
            |-> rd_data_o == {role[1:0], 2'h0, role[2], 3'h0};
    endproperty
    a_mode_rd: assert property (p_mode_rd) else $error("mode read bad");
    property p_tcon_rd;
        $past(bus_req_i.rd) && $past(bus_req_i.addr) == `SCPW_OFS_TCON
            |-> rd_data_o == {5'h00, tcon};
    endproperty
    a_tcon_rd: assert property (p_tcon_rd) else $error("tcon read bad");
    property p_oe;
        sync_clock_pin_oe_o == (role == `SCPW_ROLE_CODE_MASTER);
    endproperty
    a_oe: assert property (p_oe) else $error("sync enable bad");
    property p_master;
        sync_clock_pin_oe_o |-> sync_clock_pin_o == clock_output_pin_o;
    endproperty
    a_master: assert property (p_master) else $error("sync pin bad");
    property p_gate;
        primary_gate_drive_o |-> !clock_output_pin_o;
    endproperty
    a_gate: assert property (p_gate) else $error("gate in high");
    property p_sleep_clk;
        $past(sleep_i) |-> $stable(clock_output_pin_o);
    endproperty
    a_sleep_clk: assert property (p_sleep_clk) else $error("pin moved");
    property p_sleep_gate;
        sleep_i |=> $stable(primary_gate_drive_o);
    endproperty
    a_sleep_gate: assert property (p_sleep_gate) else $error("gate moved");
    property p_period;
        period_match_o && ok == 2'h2 |-> gap == (16'(plim) + 16'h1) * ratio;
    endproperty
    a_period: assert property (p_period) else $error("period bad");
    property p_high;
        ok == 2'h2 && $fell(clock_output_pin_o) |-> hi == 16'(drun) * ratio;
    endproperty
    a_high: assert property (p_high) else $error("high bad");
endmodule
bind scpw_top scpw_top_props u_props (
    .core_clk_i(core_clk_i), .rst_i(rst_i), .bus_req_i(bus_req_i),
    .rd_data_o(rd_data_o), .sleep_i(sleep_i),
    .sync_clock_pin_i(sync_clock_pin_i), .sync_clock_pin_o(sync_clock_pin_o),
    .sync_clock_pin_oe_o(sync_clock_pin_oe_o),
    .clock_output_pin_o(clock_output_pin_o),
    .drive_request_i(drive_request_i),
    .primary_gate_drive_o(primary_gate_drive_o),
    .period_match_o(period_match_o)
);

// [scpw_peer.sv]
`timescale 1ns/1ps
module scpw_peer (
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic en_i,
    input wire logic [7:0] per_i,
    output logic pin_o,
    output logic oe_o
);
    logic [7:0] cnt;
    // Master system clock, high for the first half of each period
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i)
            cnt <= 8'h00;
        else
            cnt <= (cnt + 8'h01 >= per_i) ? 8'h00 : cnt + 8'h01;
    end
    // Driven only while acting as master, else left to the pull-up
    assign pin_o = en_i && (cnt < (per_i >> 1));
    assign oe_o = en_i;
endmodule

// [scpw_top_test.sv]
`timescale 1ns/1ps
`include "scpw_map.svh"
module scpw_top_test import scpw_pkg::*;;
    logic core_clk_i;
    logic rst_i;
    scpw_bus_req_t req;
    logic [7:0] rdat, plim, duty, v, c1;
    logic sleep, drq, so, soe, co, gd, pm, prev;
    logic peer_en, peer_o, peer_oe, pin;
    int errors, check_count, n, d0, k;
    // Pull-up wins when neither side drives the sync pin
    assign pin = soe ? so : (peer_oe ? peer_o : 1'b1);
    scpw_top u_dut (.core_clk_i(core_clk_i), .rst_i(rst_i), .bus_req_i(req),
        .rd_data_o(rdat), .sleep_i(sleep), .sync_clock_pin_i(pin),
        .sync_clock_pin_o(so), .sync_clock_pin_oe_o(soe),
        .clock_output_pin_o(co), .drive_request_i(drq),
        .primary_gate_drive_o(gd), .period_match_o(pm));
    scpw_peer u_peer (.core_clk_i(core_clk_i), .rst_i(rst_i), .en_i(peer_en),
        .per_i(8'd40), .pin_o(peer_o), .oe_o(peer_oe));
    // 20 MHz clock
    initial begin
        core_clk_i = 1'b0;
        forever #25 core_clk_i = ~core_clk_i;
    end
    // Random gate requests keep the driver path busy
    always @(posedge core_clk_i) drq <= 1'($urandom);
    function automatic logic [15:0] ratio_of(input logic [1:0] ps);
        return (ps == 2'h0) ? 16'h1 : (ps == 2'h1) ? 16'h4 : 16'h10;
    endfunction
    task automatic chk(input string what, input logic [15:0] seen, exp);
        check_count++;
        if (seen !== exp) begin
            errors++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", check_count, errors);
        if (errors == 0 && check_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge core_clk_i);
        req.addr <= a;
        req.wdata <= d;
        req.wr <= 1'b1;
        @(posedge core_clk_i);
        req.wr <= 1'b0;
    endtask
    task automatic rd(input logic [2:0] a, output logic [7:0] d);
        @(posedge core_clk_i);
        req.addr <= a;
        req.rd <= 1'b1;
        @(posedge core_clk_i);
        req.rd <= 1'b0;
        @(negedge core_clk_i);
        d = rdat;
    endtask
    // Cycles until a rise of clock out (0), sync pin (1) or match (2)
    task automatic wait_rise(input int sel, output int cnt);
        logic p;
        logic c;
        cnt = 0;
        p = (sel == 0) ? co : (sel == 1) ? pin : pm;
        // Bound covers a limit lowered below the count: a wrap through 255
        while (cnt < 6000) begin
            @(negedge core_clk_i);
            cnt++;
            c = (sel == 0) ? co : (sel == 1) ? pin : pm;
            if (!p && c)
                return;
            p = c;
        end
        errors++;
        report_and_stop;
    endtask
    initial begin
        req = '0;
        sleep = 1'b0;
        drq = 1'b0;
        peer_en = 1'b0;
        rst_i = 1'b1;
        v = 8'($urandom(45));
        repeat (20) @(posedge core_clk_i);
        rst_i <= 1'b0;
        // Reset values, unimplemented bits and read-only places
        for (int a = 0; a < 8; a++) begin
            rd(3'(a), v);
            chk("reset value", 16'(v), 16'h0);
        end
        wr(`SCPW_OFS_MODE, 8'hff);
        wr(`SCPW_OFS_TCON, 8'hff);
        wr(`SCPW_OFS_DACT, 8'hff);
        rd(`SCPW_OFS_MODE, v);
        chk("mode bits", 16'(v), 16'hc8);
        rd(`SCPW_OFS_TCON, v);
        chk("tcon bits", 16'(v), 16'h7);
        rd(`SCPW_OFS_DACT, v);
        chk("duty active ro", 16'(v), 16'h0);
        $display("test registers done");
        wr(`SCPW_OFS_MODE, 8'h00);
        // Every prescale code with a random limit and duty
        for (int ps = 0; ps < 4; ps++) begin
            plim = 8'(2 + $urandom % 30);
            duty = 8'(1 + $urandom % plim);
            wr(`SCPW_OFS_PLIM, plim);
            wr(`SCPW_OFS_DUTY, duty);
            wr(`SCPW_OFS_TCON, 8'(4 + ps));
            repeat (3) wait_rise(2, n);
            chk("period", 16'(n), (16'(plim) + 16'h1) * ratio_of(2'(ps)));
            wait_rise(0, n);
            k = 0;
            while (co === 1'b1 && k < 5000) begin
                k++;
                @(negedge core_clk_i);
            end
            if (k >= 5000) begin
                errors++;
                report_and_stop;
            end
            chk("high time", 16'(k), 16'(duty) * ratio_of(2'(ps)));
            $display("test prescale %0d done", ps);
        end
        // Duty write in mid-period waits for the next match
        v = (duty == 8'h01) ? 8'h02 : 8'h01;
        wait_rise(2, n);
        repeat (3) @(posedge core_clk_i);
        wr(`SCPW_OFS_DUTY, v);
        rd(`SCPW_OFS_DACT, c1);
        chk("duty held", 16'(c1), 16'(duty));
        wait_rise(2, n);
        rd(`SCPW_OFS_DACT, c1);
        chk("duty loaded", 16'(c1), 16'(v));
        $display("test duty update done");
        // Sleep freezes the count and the pin, wake resumes
        @(posedge core_clk_i);
        sleep <= 1'b1;
        rd(`SCPW_OFS_COUNT, c1);
        prev = co;
        repeat (40) @(posedge core_clk_i);
        rd(`SCPW_OFS_COUNT, v);
        chk("frozen count", 16'(v), 16'(c1));
        chk("pin held", 16'(co), 16'(prev));
        @(posedge core_clk_i);
        sleep <= 1'b0;
        rd(`SCPW_OFS_COUNT, v);
        chk("resume", 16'(v == c1 || v == c1 + 8'h01 ||
            (v == 8'h00 && c1 == plim)), 16'h1);
        $display("test sleep done");
        // Master drives its clock onto the sync pin
        wr(`SCPW_OFS_MODE, 8'h40);
        repeat (3) @(posedge core_clk_i);
        @(negedge core_clk_i);
        chk("sync enable", 16'(soe), 16'h1);
        chk("sync level", 16'(pin), 16'(co));
        // Slave follows a faster master clock
        wr(`SCPW_OFS_MODE, 8'h80);
        wr(`SCPW_OFS_TCON, 8'h04);
        wr(`SCPW_OFS_PLIM, 8'hff);
        wr(`SCPW_OFS_DUTY, 8'h0a);
        wr(`SCPW_OFS_PHASE, 8'h00);
        peer_en <= 1'b1;
        repeat (2) wait_rise(1, n);
        k = 0;
        prev = co;
        repeat (400) begin
            @(negedge core_clk_i);
            if (co && !prev)
                k++;
            prev = co;
        end
        chk("slave rises", 16'(k), 16'd10);
        rd(`SCPW_OFS_DACT, v);
        chk("slave duty", 16'(v), 16'h0a);
        wait_rise(1, n);
        wait_rise(0, d0);
        wr(`SCPW_OFS_PHASE, 8'h08);
        repeat (2) wait_rise(1, n);
        rd(`SCPW_OFS_PACT, v);
        chk("slave phase", 16'(v), 16'h8);
        wait_rise(1, n);
        wait_rise(0, n);
        chk("phase delay", 16'(n - d0), 16'd8);
        $display("test sync done");
        report_and_stop;
    end
endmodule
